/* File: udc_params.svh */
// Register map, field positions and reset values of the counter bank
`ifndef UDC_PARAMS_SVH
`define UDC_PARAMS_SVH
`define UDC_NUM          8
`define UDC_OFS_CTRL     12'h000
`define UDC_OFS_ISTAT    12'h004
`define UDC_OFS_IMASK    12'h008
`define UDC_OFS_STAMP    12'h00c
`define UDC_CNT_PAGE     4'h1
`define UDC_FLD_PRESET   3'h0
`define UDC_FLD_COMPARE  3'h1
`define UDC_FLD_COUNT    3'h2
`define UDC_FLD_CAPT     3'h3
`define UDC_FLD_CTIME    3'h4
`define UDC_FLD_FLAGS    3'h5
`define UDC_CTRL_RST     8'h00
`define UDC_ISTAT_RST    16'h0000
`define UDC_IMASK_RST    16'h0000
`define UDC_PRESET_RST   32'h0000_0000
`define UDC_COMPARE_RST  32'h0000_0000
`define UDC_STAMP_RST    32'h0000_0000
`define UDC_ZERO         32'sh0000_0000
`define UDC_ONE          32'sh0000_0001
`define UDC_MAX_POS      32'sh7fff_ffff
`define UDC_MIN_NEG      32'sh8000_0000
`endif

/* File: udc_pkg.sv */
// Types shared by the counter bank and its per-counter core
`default_nettype none
package udc_pkg;
  typedef logic signed [31:0] udc_word_type;

  typedef struct packed {
    logic       hit;
    logic       glob;
    logic [2:0] idx;
    logic [2:0] fld;
  } udc_dec_type;

  typedef struct packed {
    logic         prev_up;
    logic         prev_dn;
    logic         prev_ld;
    logic         prev_en;
    udc_word_type count;
    udc_word_type capture;
    logic [31:0]  cap_stamp;
    logic         above;
    logic         equal;
    logic         below;
    logic         match_evt;
    logic         frz_evt;
  } udc_core_state_type;

  typedef struct packed {
    logic [7:0]       ctrl_en;
    logic [15:0]      int_stat;
    logic [15:0]      int_mask;
    logic [31:0]      stamp;
    logic [7:0][31:0] preset;
    logic [7:0][31:0] compare;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
  } udc_top_state_type;
endpackage
`default_nettype wire

/* File: udc_core_if.sv */
// Signals between the register bank and one counter core
`timescale 1ns/10ps
`default_nettype none
interface udc_core_if;
  import udc_pkg::*;
  logic         en;
  udc_word_type preset;
  udc_word_type compare;
  logic         up;
  logic         down;
  logic         blk;
  logic         ld_sel;
  logic         rst_cmd;
  logic         frz_rst;
  logic         frz_cnt;
  logic [31:0]  stamp;
  udc_word_type count;
  udc_word_type capture;
  logic [31:0]  cap_stamp;
  logic         above;
  logic         equal;
  logic         below;
  logic         match_evt;
  logic         frz_evt;

  modport bank (output en, preset, compare, up, down, blk, ld_sel, rst_cmd,
                output frz_rst, frz_cnt, stamp,
                input count, capture, cap_stamp, above, equal, below,
                input match_evt, frz_evt);
  modport core (input en, preset, compare, up, down, blk, ld_sel, rst_cmd,
                input frz_rst, frz_cnt, stamp,
                output count, capture, cap_stamp, above, equal, below,
                output match_evt, frz_evt);
endinterface
`default_nettype wire

/* File: udc_core.sv */
// One signed up/down edge counter with compare flags and freeze capture
`timescale 1ns/10ps
`default_nettype none
`include "udc_params.svh"
module udc_core
  import udc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  udc_core_if.core bus
);
  udc_core_state_type q;
  udc_core_state_type d;
  logic               up_rise;
  logic               dn_rise;
  logic               ld_rise;
  logic               en_rise;
  logic               counting;

  // Edges against last cycle's sample, so a held level counts once
  assign up_rise  = bus.up & ~q.prev_up;
  assign dn_rise  = bus.down & ~q.prev_dn;
  assign ld_rise  = bus.ld_sel & ~q.prev_ld;
  assign en_rise  = bus.en & ~q.prev_en;
  // Blocked edges are still sampled, so unblocking makes no false edge
  assign counting = bus.en & q.prev_en & ~bus.blk;

  always_comb
  begin
    d           = q;
    d.prev_up   = bus.up;
    d.prev_dn   = bus.down;
    d.prev_ld   = bus.ld_sel;
    d.prev_en   = bus.en;
    d.match_evt = 1'b0;
    d.frz_evt   = 1'b0;
    if (bus.frz_rst | bus.frz_cnt)
    begin
      d.capture   = q.count;
      d.cap_stamp = bus.stamp;
      d.frz_evt   = 1'b1;
    end
    if (bus.rst_cmd)
      d.count = bus.ld_sel ? bus.preset : `UDC_ZERO;
    else if (bus.frz_rst)
      d.count = `UDC_ZERO;
    else if (en_rise)
      d.count = bus.ld_sel ? bus.preset : `UDC_ZERO;
    else if (bus.en & ld_rise)
      d.count = bus.preset;
    else if (counting & up_rise & ~dn_rise)
      d.count = q.count + `UDC_ONE;
    else if (counting & dn_rise & ~up_rise)
      d.count = q.count - `UDC_ONE;
    if (bus.blk)
    begin
      d.above = 1'b0;
      d.equal = 1'b0;
      d.below = 1'b0;
    end
    else
    begin
      d.above = d.count > bus.compare;
      d.equal = d.count == bus.compare;
      d.below = d.count < bus.compare;
    end
    d.match_evt = d.equal & ~q.equal;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign bus.count     = q.count;
  assign bus.capture   = q.capture;
  assign bus.cap_stamp = q.cap_stamp;
  assign bus.above     = q.above;
  assign bus.equal     = q.equal;
  assign bus.below     = q.below;
  assign bus.match_evt = q.match_evt;
  assign bus.frz_evt   = q.frz_evt;

  logic quiet;
  assign quiet = counting & ~bus.rst_cmd & ~bus.frz_rst & ~ld_rise;

  AST_UP_INC:
  assert property (@(posedge clk) disable iff (!rst_n)
    quiet && up_rise && !dn_rise |=> q.count == $past(q.count) + `UDC_ONE)
    else $error("up edge did not add one");
  AST_UP_WRAP:
  assert property (@(posedge clk) disable iff (!rst_n)
    quiet && up_rise && !dn_rise && q.count == `UDC_MAX_POS
    |=> q.count == `UDC_MIN_NEG)
    else $error("up wrap at positive limit failed");
  AST_DN_DEC:
  assert property (@(posedge clk) disable iff (!rst_n)
    quiet && dn_rise && !up_rise |=> q.count == $past(q.count) - `UDC_ONE)
    else $error("down edge did not subtract one");
  AST_DN_WRAP:
  assert property (@(posedge clk) disable iff (!rst_n)
    quiet && dn_rise && !up_rise && q.count == `UDC_MIN_NEG
    |=> q.count == `UDC_MAX_POS)
    else $error("down wrap at negative limit failed");
  AST_FLAGS:
  assert property (@(posedge clk) disable iff (!rst_n)
    !bus.blk && $stable(bus.compare) |=> $onehot({q.above, q.equal, q.below})
    && q.equal == (q.count == $past(bus.compare)))
    else $error("compare flags wrong");
  AST_BLOCK:
  assert property (@(posedge clk) disable iff (!rst_n)
    bus.blk && !bus.rst_cmd && !bus.frz_rst && !en_rise && !ld_rise
    |=> !q.above && !q.equal && !q.below && $stable(q.count))
    else $error("blocked counter changed or flagged");
  AST_LOAD:
  assert property (@(posedge clk) disable iff (!rst_n)
    bus.en && q.prev_en && ld_rise && !bus.rst_cmd && !bus.frz_rst
    |=> q.count == $past(bus.preset))
    else $error("preset not loaded on select rise");
  AST_RESET:
  assert property (@(posedge clk) disable iff (!rst_n)
    bus.rst_cmd |=> q.count == ($past(bus.ld_sel) ? $past(bus.preset)
    : `UDC_ZERO))
    else $error("reset command loaded wrong value");
  AST_FRZ_RST:
  assert property (@(posedge clk) disable iff (!rst_n)
    bus.frz_rst && !bus.rst_cmd |=> q.count == `UDC_ZERO
    && q.capture == $past(q.count) && q.cap_stamp == $past(bus.stamp))
    else $error("freeze and reset failed");
  AST_FRZ_CNT:
  assert property (@(posedge clk) disable iff (!rst_n)
    bus.frz_cnt && !bus.frz_rst && !bus.rst_cmd && !en_rise && !ld_rise
    && !(counting && up_rise != dn_rise)
    |=> q.capture == $past(q.count) && $stable(q.count))
    else $error("freeze and count altered the count");
endmodule
`default_nettype wire

/* File: udc_top.sv */
// Bank of eight up/down event counters with APB registers and interrupt
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "udc_params.svh"
module udc_top
  import udc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [7:0]  cnt_up,
  input  wire logic [7:0]  cnt_down,
  input  wire logic [7:0]  cnt_block,
  input  wire logic [7:0]  preset_load_select,
  input  wire logic [7:0]  cnt_reset,
  input  wire logic [7:0]  cnt_freeze_reset,
  input  wire logic [7:0]  cnt_freeze_count,
  output var  logic [7:0]  count_above_compare,
  output var  logic [7:0]  count_matches_compare,
  output var  logic [7:0]  count_below_compare,
  output var  logic        irq
);
  udc_top_state_type q;
  udc_top_state_type d;
  logic [7:0][31:0]  count_w;
  logic [7:0][31:0]  capt_w;
  logic [7:0][31:0]  ctime_w;
  logic [7:0][2:0]   flags_w;
  logic [7:0]        match_w;
  logic [7:0]        frz_w;
  udc_dec_type       dec;
  logic              setup;
  logic              access;
  logic [15:0]       w1c;

  // Same decode serves the setup-phase read and the access-phase write
  function automatic udc_dec_type decode(input logic [11:0] a);
    udc_dec_type r;
    r      = '0;
    r.idx  = a[7:5];
    r.fld  = a[4:2];
    if (a == `UDC_OFS_CTRL || a == `UDC_OFS_ISTAT ||
        a == `UDC_OFS_IMASK || a == `UDC_OFS_STAMP)
    begin
      r.hit  = 1'b1;
      r.glob = 1'b1;
    end
    else if (a[11:8] == `UDC_CNT_PAGE && a[1:0] == 2'h0 &&
             a[4:2] <= `UDC_FLD_FLAGS)
      r.hit = 1'b1;
    return r;
  endfunction

  udc_core_if ifc [`UDC_NUM] ();

  genvar gi;
  generate
    for (gi = 0; gi < `UDC_NUM; gi++)
    begin : g_cnt
      assign ifc[gi].en      = q.ctrl_en[gi];
      assign ifc[gi].preset  = q.preset[gi];
      assign ifc[gi].compare = q.compare[gi];
      assign ifc[gi].up      = cnt_up[gi];
      assign ifc[gi].down    = cnt_down[gi];
      assign ifc[gi].blk     = cnt_block[gi];
      assign ifc[gi].ld_sel  = preset_load_select[gi];
      assign ifc[gi].rst_cmd = cnt_reset[gi];
      assign ifc[gi].frz_rst = cnt_freeze_reset[gi];
      assign ifc[gi].frz_cnt = cnt_freeze_count[gi];
      assign ifc[gi].stamp   = q.stamp;
      assign count_w[gi]     = ifc[gi].count;
      assign capt_w[gi]      = ifc[gi].capture;
      assign ctime_w[gi]     = ifc[gi].cap_stamp;
      assign flags_w[gi]     = {ifc[gi].below, ifc[gi].equal, ifc[gi].above};
      assign match_w[gi]     = ifc[gi].match_evt;
      assign frz_w[gi]       = ifc[gi].frz_evt;
      assign count_above_compare[gi]   = ifc[gi].above;
      assign count_matches_compare[gi] = ifc[gi].equal;
      assign count_below_compare[gi]   = ifc[gi].below;
      udc_core u_core
      (
        .clk   (pclk),
        .rst_n (presetn),
        .bus   (ifc[gi])
      );
    end
  endgenerate

  assign dec    = decode(paddr);
  assign setup  = psel & ~penable;
  // Writes land only on the edge where the access phase sees pready
  assign access = psel & penable & q.pready;
  assign w1c    = (access & pwrite & dec.hit & dec.glob &
                   paddr == `UDC_OFS_ISTAT) ? pwdata[15:0] : 16'h0000;

  always_comb
  begin
    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0000_0000;
    d.stamp   = q.stamp + 32'h0000_0001;
    if (setup)
    begin
      // Read data is taken in setup so all outputs stay registered
      d.pready  = 1'b1;
      d.pslverr = ~dec.hit;
      if (dec.hit & ~pwrite)
      begin
        if (dec.glob)
        begin
          case (paddr)
            `UDC_OFS_CTRL:  d.prdata = {24'h000000, q.ctrl_en};
            `UDC_OFS_ISTAT: d.prdata = {16'h0000, q.int_stat};
            `UDC_OFS_IMASK: d.prdata = {16'h0000, q.int_mask};
            `UDC_OFS_STAMP: d.prdata = q.stamp;
            default:        d.prdata = 32'h0000_0000;
          endcase
        end
        else
        begin
          case (dec.fld)
            `UDC_FLD_PRESET:  d.prdata = q.preset[dec.idx];
            `UDC_FLD_COMPARE: d.prdata = q.compare[dec.idx];
            `UDC_FLD_COUNT:   d.prdata = count_w[dec.idx];
            `UDC_FLD_CAPT:    d.prdata = capt_w[dec.idx];
            `UDC_FLD_CTIME:   d.prdata = ctime_w[dec.idx];
            `UDC_FLD_FLAGS:   d.prdata = {29'h0000_0000, flags_w[dec.idx]};
            default:          d.prdata = 32'h0000_0000;
          endcase
        end
      end
    end
    if (access & pwrite & dec.hit)
    begin
      if (dec.glob)
      begin
        case (paddr)
          `UDC_OFS_CTRL:  d.ctrl_en  = pwdata[7:0];
          `UDC_OFS_IMASK: d.int_mask = pwdata[15:0];
          default:        d.ctrl_en  = q.ctrl_en;
        endcase
      end
      else
      begin
        case (dec.fld)
          `UDC_FLD_PRESET:  d.preset[dec.idx]  = pwdata;
          `UDC_FLD_COMPARE: d.compare[dec.idx] = pwdata;
          default:          d.preset[dec.idx]  = q.preset[dec.idx];
        endcase
      end
    end
    // A new event in the clearing cycle survives the clear
    d.int_stat = (q.int_stat & ~w1c) | {frz_w, match_w};
    d.irq      = |(d.int_stat & d.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.ctrl_en  <= `UDC_CTRL_RST;
      q.int_stat <= `UDC_ISTAT_RST;
      q.int_mask <= `UDC_IMASK_RST;
      q.stamp    <= `UDC_STAMP_RST;
      q.preset   <= {`UDC_NUM{`UDC_PRESET_RST}};
      q.compare  <= {`UDC_NUM{`UDC_COMPARE_RST}};
    end
    else
      q <= d;
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;

  AST_SLOT_MATCH:
  assert property (@(posedge pclk) disable iff (!presetn)
    match_w != 8'h00 |=> (q.int_stat[7:0] & $past(match_w)) == $past(match_w))
    else $error("match event not latched in its own slot");
  AST_SET_WINS:
  assert property (@(posedge pclk) disable iff (!presetn)
    frz_w != 8'h00 |=> (q.int_stat[15:8] & $past(frz_w)) == $past(frz_w))
    else $error("freeze event lost against clear");
  AST_PRESET_WR:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_PRESET
    |=> q.preset[$past(dec.idx)] == $past(pwdata))
    else $error("preset write not stored");
  AST_COMPARE_WR:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_COMPARE
    |=> q.compare[$past(dec.idx)] == $past(pwdata))
    else $error("compare write not stored");
  AST_CTRL_WR:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `UDC_OFS_CTRL
    |=> q.ctrl_en == $past(pwdata[7:0]))
    else $error("enable write not stored");
  AST_IMASK_WR:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `UDC_OFS_IMASK
    |=> q.int_mask == $past(pwdata[15:0]))
    else $error("mask write not stored");
  AST_W1C:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `UDC_OFS_ISTAT && frz_w == 8'h00 &&
    match_w == 8'h00 |=> (q.int_stat & $past(pwdata[15:0])) == 16'h0000)
    else $error("status bit not cleared by one");
  // A refused write must leave every setting as it was
  AST_REFUSED:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !dec.hit |=> $stable(q.ctrl_en) &&
    $stable(q.int_mask) && $stable(q.preset) && $stable(q.compare))
    else $error("unmapped write changed a register");
  AST_RO_FIELDS:
  assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && dec.hit && !dec.glob &&
    dec.fld >= `UDC_FLD_COUNT |=> $stable(q.preset) && $stable(q.compare))
    else $error("read-only field write changed a setting");
  // Reads return what stood at the setup edge
  AST_RD_PRESET:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_PRESET
    |=> prdata == $past(q.preset[dec.idx]))
    else $error("preset read back wrong");
  AST_RD_COMPARE:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_COMPARE
    |=> prdata == $past(q.compare[dec.idx]))
    else $error("compare read back wrong");
  AST_RD_COUNT:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_COUNT
    |=> prdata == $past(count_w[dec.idx]))
    else $error("count read back wrong");
  AST_RD_CAPT:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_CAPT
    |=> prdata == $past(capt_w[dec.idx]))
    else $error("capture read back wrong");
  AST_RD_FLAGS:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.glob && dec.fld == `UDC_FLD_FLAGS
    |=> prdata == {29'h0000_0000, $past(flags_w[dec.idx])})
    else $error("flags read back wrong");
  AST_PREADY_ONE:
  assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no ready after setup");
  AST_PREADY_DROP:
  assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past one cycle");
  AST_SLVERR:
  assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without ready or with data");
  // Pin flags trail the block input by one cycle
  AST_PIN_ONEHOT:
  assert property (@(posedge pclk) disable iff (!presetn)
    (count_above_compare & count_matches_compare) == 8'h00 &&
    (count_above_compare & count_below_compare) == 8'h00 &&
    (count_matches_compare & count_below_compare) == 8'h00)
    else $error("two compare flags high together");
  AST_PIN_BLOCK:
  assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((count_above_compare | count_matches_compare |
    count_below_compare) & $past(cnt_block)) == 8'h00)
    else $error("blocked counter shows a flag");
  AST_PIN_SET:
  assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (count_above_compare | count_matches_compare |
    count_below_compare | $past(cnt_block)) == 8'hff)
    else $error("unblocked counter shows no flag");
  AST_IRQ_LEVEL:
  assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == ((q.int_stat & q.int_mask) != 16'h0000))
    else $error("interrupt level disagrees with status");
  AST_STAMP_RUN:
  assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> q.stamp == $past(q.stamp) + 32'h0000_0001)
    else $error("time stamp did not advance");
endmodule
`default_nettype wire

/* File: udc_net_model.sv */
// Logic operand network that drives the counter bank inputs
`timescale 1ns/10ps
`default_nettype none
module udc_net_model
(
  input  wire logic       clk,
  output wire logic [7:0] cnt_up,
  output wire logic [7:0] cnt_down,
  output wire logic [7:0] cnt_block,
  output wire logic [7:0] preset_load_select,
  output wire logic [7:0] cnt_reset,
  output wire logic [7:0] cnt_freeze_reset,
  output wire logic [7:0] cnt_freeze_count
);
  logic [4:0][7:0] cmd_q;
  logic [1:0][7:0] lvl_q;

  initial
  begin
    cmd_q = '0;
    lvl_q = '0;
  end

  assign cnt_up             = cmd_q[0];
  assign cnt_down           = cmd_q[1];
  assign cnt_reset          = cmd_q[2];
  assign cnt_freeze_reset   = cmd_q[3];
  assign cnt_freeze_count   = cmd_q[4];
  assign cnt_block          = lvl_q[0];
  assign preset_load_select = lvl_q[1];

  // One-cycle pulse, then a quiet cycle so the next pulse is a fresh edge
  task automatic pulse(input int sel, input int i);
    @(posedge clk);
    cmd_q[sel][i] <= 1'b1;
    @(posedge clk);
    cmd_q[sel][i] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic level(input int sel, input int i, input logic v);
    @(posedge clk);
    lvl_q[sel][i] <= v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: updown_event_counter_compare_tb.sv */
// Self-checking bench for the counter bank over APB
`timescale 1ns/10ps
`default_nettype none
module updown_event_counter_compare_tb;
  import udc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [7:0]  up, dn, blk, sel, rst, frz_r, frz_c, above, equal, below;
  int          err_count;
  int          checks_done;
  int          cycles;

  udc_net_model udc_net_model_i (.clk(pclk), .cnt_up(up), .cnt_down(dn),
    .cnt_block(blk), .preset_load_select(sel), .cnt_reset(rst),
    .cnt_freeze_reset(frz_r), .cnt_freeze_count(frz_c));

  udc_top udc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_up(up),
    .cnt_down(dn), .cnt_block(blk), .preset_load_select(sel),
    .cnt_reset(rst), .cnt_freeze_reset(frz_r), .cnt_freeze_count(frz_c),
    .count_above_compare(above), .count_matches_compare(equal),
    .count_below_compare(below), .irq(irq));

  always #2.5 pclk = ~pclk;

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done = checks_done + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  // Request held until pready is sampled high, released only after it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
                        input string n);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    chk(n, x, d);
  endtask

  function automatic logic [11:0] ca(input int i, input logic [4:0] off);
    return 12'h100 + 12'(i * 32) + {7'h00, off};
  endfunction

  task automatic chk_irq(input logic x);
    @(posedge pclk);
    #1;
    chk("irq", {31'h0, x}, {31'h0, irq});
  endtask

  task automatic chk_flags(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] b);
    @(posedge pclk);
    #1;
    chk("above", {24'h0, a}, {24'h0, above});
    chk("equal", {24'h0, m}, {24'h0, equal});
    chk("below", {24'h0, b}, {24'h0, below});
  endtask

  initial
  begin
    logic [31:0] d;
    logic        e;
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h000, 32'h0000_0000, "ctrl");
    chk_flags(8'h00, 8'hff, 8'h00);
    apb(1'b0, 12'h0f0, 32'h0000_0000, d, e);
    chk("pslverr", 32'h0000_0001, {31'h0, e});
    chk("unmapped_rd", 32'h0000_0000, d);
    apb(1'b1, 12'h0f0, 32'h0000_00ff, d, e);
    chk("pslverr", 32'h0000_0001, {31'h0, e});
    rd_chk(12'h000, 32'h0000_0000, "ctrl");
    wr(ca(0, 5'h04), 32'h0000_0002);
    rd_chk(ca(0, 5'h04), 32'h0000_0002, "compare0");
    // Clear the match events that every counter raised just after reset
    wr(12'h004, 32'h0000_ffff);
    wr(12'h000, 32'h0000_00ff);
    rd_chk(ca(0, 5'h08), 32'h0000_0000, "count0");
    wr(ca(0, 5'h08), 32'h0000_1234);
    rd_chk(ca(0, 5'h08), 32'h0000_0000, "count0");
    udc_net_model_i.pulse(0, 0);
    udc_net_model_i.pulse(0, 0);
    rd_chk(ca(0, 5'h08), 32'h0000_0002, "count0");
    rd_chk(ca(0, 5'h14), 32'h0000_0002, "flags0");
    rd_chk(12'h004, 32'h0000_0001, "istat");
    wr(12'h008, 32'h0000_0001);
    chk_irq(1'b1);
    wr(12'h004, 32'h0000_ffff);
    chk_irq(1'b0);
    udc_net_model_i.pulse(1, 0);
    rd_chk(ca(0, 5'h08), 32'h0000_0001, "count0");
    rd_chk(ca(0, 5'h14), 32'h0000_0004, "flags0");
    for (int i = 1; i < 8; i++)
    begin
      udc_net_model_i.pulse(0, i);
      rd_chk(ca(i, 5'h08), 32'h0000_0001, "count_i");
    end
    rd_chk(ca(0, 5'h08), 32'h0000_0001, "count0");
    chk_flags(8'hfe, 8'h00, 8'h01);
    wr(ca(0, 5'h00), 32'h7fff_ffff);
    rd_chk(ca(0, 5'h00), 32'h7fff_ffff, "preset0");
    udc_net_model_i.level(1, 0, 1'b1);
    rd_chk(ca(0, 5'h08), 32'h7fff_ffff, "count0");
    rd_chk(ca(0, 5'h14), 32'h0000_0001, "flags0");
    udc_net_model_i.level(1, 0, 1'b0);
    rd_chk(ca(0, 5'h08), 32'h7fff_ffff, "count0");
    udc_net_model_i.pulse(0, 0);
    rd_chk(ca(0, 5'h08), 32'h8000_0000, "count0");
    udc_net_model_i.pulse(1, 0);
    rd_chk(ca(0, 5'h08), 32'h7fff_ffff, "count0");
    udc_net_model_i.pulse(4, 0);
    rd_chk(ca(0, 5'h0c), 32'h7fff_ffff, "capture0");
    rd_chk(ca(0, 5'h08), 32'h7fff_ffff, "count0");
    udc_net_model_i.pulse(0, 0);
    udc_net_model_i.pulse(3, 0);
    rd_chk(ca(0, 5'h0c), 32'h8000_0000, "capture0");
    rd_chk(ca(0, 5'h08), 32'h0000_0000, "count0");
    rd_chk(12'h004, 32'h0000_0100, "istat");
    udc_net_model_i.level(0, 0, 1'b1);
    udc_net_model_i.pulse(0, 0);
    rd_chk(ca(0, 5'h08), 32'h0000_0000, "count0");
    rd_chk(ca(0, 5'h14), 32'h0000_0000, "flags0");
    chk_flags(8'hfe, 8'h00, 8'h00);
    udc_net_model_i.level(0, 0, 1'b0);
    udc_net_model_i.level(1, 0, 1'b1);
    udc_net_model_i.pulse(0, 0);
    udc_net_model_i.pulse(2, 0);
    rd_chk(ca(0, 5'h08), 32'h7fff_ffff, "count0");
    udc_net_model_i.level(1, 0, 1'b0);
    udc_net_model_i.pulse(2, 0);
    rd_chk(ca(0, 5'h08), 32'h0000_0000, "count0");
    wrap_up();
  end
endmodule
`default_nettype wire
